//--- rtl/tbc_defines.svh
// Register indices, reset values and bus codes of the timer channel block.
// Operation
// - Channel interrupt requested only when enable set.
// - Buffered select exists in channel 0 only.
// - Buffered mode disables channel 1 control, pin.
// - Nonzero edge code: select A picks capture/compare.
// - Edge code 00: select A sets preset level.
// - Capture on rising, falling or either edge.
// - Compare match: none, toggle, clear, set pin.
// - Edge code 00 releases pin to port.
// - Buffered mode ignores A; toggle/clear/set on compare.
// - Toggle-on-overflow toggles compare pin each overflow.
// - Overflow action beats simultaneous compare action.
// - Max duty forces high, from next period.
// - Value register holds capture or compare value.
// - Capture high-byte read blocks captures until low.
// - Compare high-byte write blocks matches until low.
// - Flag set on event; read then write-0 clears (with enable clear, a write-0 alone clears it).
// - Halt with clear holds counter at zero.
`ifndef TBC_DEFINES_SVH
`define TBC_DEFINES_SVH
`define TBC_IDX_SC0 6'h30
`define TBC_IDX_V0H 6'h31
`define TBC_IDX_V0L 6'h32
`define TBC_IDX_SC1 6'h33
`define TBC_IDX_V1H 6'h34
`define TBC_IDX_V1L 6'h35
`define TBC_SC_RESET 8'h00
`define TBC_SC_FLAG 7
`define TBC_RESP_OKAY 2'h0
`define TBC_RESP_SLVERR 2'h2
`endif

//--- rtl/tbc_pkg.sv
// Types and decoders shared by the timer channel block.
`include "tbc_defines.svh"
package tbc_pkg;
  typedef enum logic [2:0] {
    TBC_OFF = 3'b000,
    TBC_CAP = 3'b001,
    TBC_CMP = 3'b010,
    TBC_BUF = 3'b011,
    TBC_SWC = 3'b100
  } tbc_mode_t;

  typedef struct packed {
    logic channel_event_flag;
    logic channel_irq_enable;
    logic chan0_buffered_select;
    logic capture_or_compare_select;
    logic edge_level_select_hi;
    logic edge_level_select_lo;
    logic toggle_on_overflow;
    logic max_duty_force;
  } tbc_sc_t;

  function automatic tbc_mode_t tbc_mode_of(input tbc_sc_t sc, input logic off);
    if (off)
      return TBC_OFF;
    else if ({sc.edge_level_select_hi, sc.edge_level_select_lo} == 2'b00)
      return (sc.capture_or_compare_select && !sc.chan0_buffered_select) ? TBC_SWC : TBC_OFF;
    else if (sc.chan0_buffered_select)
      return TBC_BUF;
    else if (sc.capture_or_compare_select)
      return TBC_CMP;
    else
      return TBC_CAP;
  endfunction : tbc_mode_of

  function automatic logic tbc_mapped(input logic [5:0] idx);
    return (idx >= `TBC_IDX_SC0) && (idx <= `TBC_IDX_V1L);
  endfunction : tbc_mapped
endpackage : tbc_pkg

//--- rtl/tbc_reg_if.sv
// Register access strobes between the bus slave and the register file.
`timescale 1ns/100ps
interface tbc_reg_if;
  logic       wr_en;
  logic [5:0] wr_idx;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [5:0] rd_idx;
  logic [7:0] rd_data;
  modport bus (output wr_en, wr_idx, wr_data, rd_en, rd_idx, input rd_data);
  modport regs (input wr_en, wr_idx, wr_data, rd_en, rd_idx, output rd_data);
endinterface : tbc_reg_if

//--- rtl/tbc_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/100ps
`include "tbc_defines.svh"
module tbc_axil #(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  tbc_reg_if.bus                 rif
);
  import tbc_pkg::*;

  if (ADDR_W < 8)
  begin : g_chk
    $error("tbc_axil: ADDR_W must be at least 8");
  end

  logic        awready_r, awready_nxt, wready_r, wready_nxt;
  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic        bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt, wstrb0_r, wstrb0_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [5:0]  awidx_r, awidx_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_fire, ar_take;

  assign wr_fire     = aw_have_r && w_have_r && !bvalid_r;
  assign ar_take     = arvalid && arready_r;
  assign rif.wr_en   = wr_fire && wstrb0_r && tbc_mapped(awidx_r);
  assign rif.wr_idx  = awidx_r;
  assign rif.wr_data = wdata_r;
  assign rif.rd_en   = ar_take && tbc_mapped(araddr[7:2]);
  assign rif.rd_idx  = araddr[7:2];

  always_comb
  begin
    awready_nxt = awready_r;
    wready_nxt  = wready_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    awidx_nxt   = awidx_r;
    wdata_nxt   = wdata_r;
    wstrb0_nxt  = wstrb0_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (awvalid && awready_r)
    begin
      awready_nxt = 1'b0;
      aw_have_nxt = 1'b1;
      awidx_nxt   = awaddr[7:2];
    end
    if (wvalid && wready_r)
    begin
      wready_nxt = 1'b0;
      w_have_nxt = 1'b1;
      wdata_nxt  = wdata[7:0];
      wstrb0_nxt = wstrb[0];
    end
    if (wr_fire)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = tbc_mapped(awidx_r) ? `TBC_RESP_OKAY : `TBC_RESP_SLVERR;
    end
    if (bvalid_r && bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (ar_take)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = {24'h000000, rif.rd_data};
      rresp_nxt   = rif.rd_en ? `TBC_RESP_OKAY : `TBC_RESP_SLVERR;
    end
    if (rvalid_r && rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awidx_r   <= 6'h00;
      wdata_r   <= 8'h00;
      wstrb0_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `TBC_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= `TBC_RESP_OKAY;
    end
    else
    begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awidx_r   <= awidx_nxt;
      wdata_r   <= wdata_nxt;
      wstrb0_r  <= wstrb0_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign awready = awready_r;
  assign wready  = wready_r;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign arready = arready_r;
  assign rvalid  = rvalid_r;
  assign rdata   = rdata_r;
  assign rresp   = rresp_r;
endmodule : tbc_axil

//--- rtl/tbc_channel.sv
// One timer channel: edge capture, compare match and pin output.
`timescale 1ns/100ps
module tbc_channel #(
  parameter int CNT_W = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire tbc_pkg::tbc_mode_t mode,
  input  wire tbc_pkg::tbc_sc_t  sc,
  input  wire logic [CNT_W-1:0]  cnt,
  input  wire logic              ovf,
  input  wire logic [CNT_W-1:0]  cmp_val,
  input  wire logic              cap_block,
  input  wire logic              cmp_block,
  input  wire logic              pin_in,
  output logic                   cap_ev,
  output logic                   cmp_ev,
  output logic                   pin_out,
  output logic                   pin_oe_n
);
  import tbc_pkg::*;

  logic       pin_prev_r, pin_prev_nxt, out_r, out_nxt;
  logic       oe_n_r, oe_n_nxt, max_eff_r, max_eff_nxt;
  logic       rise, fall, drives, max_on;
  logic [1:0] els;

  assign els    = {sc.edge_level_select_hi, sc.edge_level_select_lo};
  assign rise   = pin_in && !pin_prev_r;
  assign fall   = !pin_in && pin_prev_r;
  assign drives = (mode == TBC_CMP) || (mode == TBC_BUF);
  // The edge history runs in every mode so a newly enabled capture sees no stale edge.
  assign cap_ev = (mode == TBC_CAP) && !cap_block && ((els[0] && rise) || (els[1] && fall));
  assign cmp_ev = (drives || mode == TBC_SWC) && !cmp_block && (cnt == cmp_val);
  assign max_on = sc.toggle_on_overflow && (els == 2'b10) && max_eff_nxt;

  always_comb
  begin
    pin_prev_nxt = pin_in;
    max_eff_nxt  = ovf ? sc.max_duty_force : max_eff_r;
    out_nxt      = out_r;
    oe_n_nxt     = !drives;
    if (mode == TBC_OFF || mode == TBC_SWC)
      out_nxt = !sc.capture_or_compare_select;
    else if (drives)
    begin
      if (max_on)
        out_nxt = 1'b1;
      else if (sc.toggle_on_overflow && ovf)
        out_nxt = !out_r;
      else if (cmp_ev)
      begin
        case (els)
          2'b01:   out_nxt = !out_r;
          2'b10:   out_nxt = 1'b0;
          2'b11:   out_nxt = 1'b1;
          default: out_nxt = out_r;
        endcase
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev_r <= 1'b0;
      out_r      <= 1'b1;
      oe_n_r     <= 1'b1;
      max_eff_r  <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin_prev_nxt;
      out_r      <= out_nxt;
      oe_n_r     <= oe_n_nxt;
      max_eff_r  <= max_eff_nxt;
    end
  end

  assign pin_out  = out_r;
  assign pin_oe_n = oe_n_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence max_armed;
    drives && ovf && sc.toggle_on_overflow && els == 2'b10 && sc.max_duty_force;
  endsequence

  preset_level_a:
  assert property ((mode == TBC_OFF) |=> (pin_out == !$past(sc.capture_or_compare_select)))
    else $error("preset level not applied");
  rise_capture_a:
  assert property ((mode == TBC_CAP && els == 2'b01 && !cap_block && rise) |-> cap_ev)
    else $error("rising edge not captured");
  pin_release_a:
  assert property ((mode == TBC_OFF || mode == TBC_CAP) |=> pin_oe_n)
    else $error("pin driven while released");
  overflow_first_a:
  assert property ((drives && sc.toggle_on_overflow && ovf && !max_on) |=> (pin_out != $past(pin_out)))
    else $error("overflow toggle lost");
  max_hold_a:
  assert property (max_armed |=> pin_out)
    else $error("max duty not forced high");
  set_on_match_a:
  assert property ((mode == TBC_CMP && els == 2'b11 && cmp_ev && !(sc.toggle_on_overflow && ovf)) |=> pin_out)
    else $error("set on compare failed");
endmodule : tbc_channel

//--- rtl/tbc_top.sv
// Two-channel timer capture/compare block with its register file and bus slave.
`timescale 1ns/100ps
`include "tbc_defines.svh"
module tbc_top #(
  parameter int CNT_W  = 16,
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic [CNT_W-1:0]  counter_value,
  input  wire logic              counter_overflow,
  input  wire logic              counter_halt,
  input  wire logic              counter_clear,
  input  wire logic [1:0]        pin_in,
  output logic [1:0]             pin_out,
  output logic [1:0]             pin_oe_n,
  output logic [1:0]             chan_irq
);
  import tbc_pkg::*;

  if (CNT_W != 16)
  begin : g_chk
    $error("tbc_top: value registers are two bytes, CNT_W must be 16");
  end

  localparam logic [5:0] SC_IDX [2] = '{`TBC_IDX_SC0, `TBC_IDX_SC1};
  localparam logic [5:0] VH_IDX [2] = '{`TBC_IDX_V0H, `TBC_IDX_V1H};
  localparam logic [5:0] VL_IDX [2] = '{`TBC_IDX_V0L, `TBC_IDX_V1L};

  tbc_reg_if rif ();

  tbc_axil #(
    .ADDR_W (ADDR_W)
  ) u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rif     (rif.bus)
  );

  tbc_sc_t          sc_r      [2];
  tbc_sc_t          sc_nxt    [2];
  logic [CNT_W-1:0] val_r     [2];
  logic [CNT_W-1:0] val_nxt   [2];
  logic [1:0]       armed_r, armed_nxt;
  logic [1:0]       cap_blk_r, cap_blk_nxt;
  logic [1:0]       cmp_blk_r, cmp_blk_nxt;
  logic [1:0]       irq_r, irq_nxt;
  logic             src_r, src_nxt;
  tbc_mode_t        mode      [2];
  logic [1:0]       ch_off, cap_ev, cmp_ev, ev;
  logic [CNT_W-1:0] cmp_val   [2];
  logic [1:0]       cmp_inh, cap_inh;
  logic [7:0]       rd_data;
  logic             held_zero;

  // A halted and cleared counter sits at zero; no compare events are taken from it.
  assign held_zero = counter_halt && counter_clear;
  assign ch_off    = {sc_r[0].chan0_buffered_select, 1'b0};

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    assign mode[g] = tbc_mode_of(sc_r[g], ch_off[g]);
    assign ev[g]   = cap_ev[g] || cmp_ev[g];
    assign cap_inh[g] = cap_blk_r[g] || counter_halt;
    if (g == 0)
    begin : g_src
      // In buffered mode the inactive value register may be rewritten safely.
      assign cmp_val[g] = (mode[0] == TBC_BUF && src_r) ? val_r[1] : val_r[0];
      assign cmp_inh[g] = ((mode[0] == TBC_BUF && src_r) ? cmp_blk_r[1] : cmp_blk_r[0]) || held_zero;
    end
    else
    begin : g_plain
      assign cmp_val[g] = val_r[g];
      assign cmp_inh[g] = cmp_blk_r[g] || held_zero;
    end

    tbc_channel #(
      .CNT_W (CNT_W)
    ) u_ch (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .mode      (mode[g]),
      .sc        (sc_r[g]),
      .cnt       (counter_value),
      .ovf       (counter_overflow),
      .cmp_val   (cmp_val[g]),
      .cap_block (cap_inh[g]),
      .cmp_block (cmp_inh[g]),
      .pin_in    (pin_in[g]),
      .cap_ev    (cap_ev[g]),
      .cmp_ev    (cmp_ev[g]),
      .pin_out   (pin_out[g]),
      .pin_oe_n  (pin_oe_n[g])
    );
  end

  always_comb
  begin
    rd_data = 8'h00;
    for (int i = 0; i < 2; i++)
    begin
      if (rif.rd_idx == SC_IDX[i])
        rd_data = ch_off[i] ? 8'h00 : sc_r[i];
      else if (rif.rd_idx == VH_IDX[i])
        rd_data = val_r[i][15:8];
      else if (rif.rd_idx == VL_IDX[i])
        rd_data = val_r[i][7:0];
    end
  end
  assign rif.rd_data = rd_data;

  always_comb
  begin
    tbc_sc_t wv;
    logic    wr_sc;
    logic    cmp_mode;
    wv       = tbc_sc_t'(rif.wr_data);
    wr_sc    = 1'b0;
    cmp_mode = 1'b0;
    src_nxt  = src_r;
    if (mode[0] != TBC_BUF)
      src_nxt = 1'b0;
    else if (counter_overflow)
      src_nxt = !src_r;
    for (int i = 0; i < 2; i++)
    begin
      sc_nxt[i]      = sc_r[i];
      val_nxt[i]     = val_r[i];
      armed_nxt[i]   = armed_r[i];
      cap_blk_nxt[i] = cap_blk_r[i];
      cmp_blk_nxt[i] = cmp_blk_r[i];
      irq_nxt[i]     = sc_r[i].channel_event_flag && sc_r[i].channel_irq_enable && !ch_off[i];
      wr_sc          = rif.wr_en && rif.wr_idx == SC_IDX[i] && !ch_off[i];
      cmp_mode       = sc_r[0].chan0_buffered_select || sc_r[i].capture_or_compare_select;
      if (rif.rd_en && rif.rd_idx == SC_IDX[i] && !ch_off[i] && sc_r[i].channel_event_flag)
        armed_nxt[i] = 1'b1;
      if (mode[i] != TBC_CAP)
        cap_blk_nxt[i] = 1'b0;
      else if (rif.rd_en && rif.rd_idx == VH_IDX[i])
        cap_blk_nxt[i] = 1'b1;
      else if (rif.rd_en && rif.rd_idx == VL_IDX[i])
        cap_blk_nxt[i] = 1'b0;
      if (wr_sc)
      begin
        sc_nxt[i] = wv;
        sc_nxt[i].channel_event_flag = sc_r[i].channel_event_flag;
        if (i != 0)
          sc_nxt[i].chan0_buffered_select = 1'b0;
        if (!wv.channel_event_flag && (armed_r[i] || !sc_r[i].channel_irq_enable))
          sc_nxt[i].channel_event_flag = 1'b0;
        armed_nxt[i] = 1'b0;
      end
      if (rif.wr_en && rif.wr_idx == VH_IDX[i])
      begin
        val_nxt[i][15:8] = rif.wr_data;
        cmp_blk_nxt[i]   = cmp_mode;
      end
      else if (rif.wr_en && rif.wr_idx == VL_IDX[i])
      begin
        val_nxt[i][7:0] = rif.wr_data;
        cmp_blk_nxt[i]  = 1'b0;
      end
      if (cap_ev[i])
        val_nxt[i] = counter_value;
      // A new event beats a clear in the same cycle and cancels a pending clear.
      if (ev[i])
      begin
        sc_nxt[i].channel_event_flag = 1'b1;
        armed_nxt[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sc_r[0]   <= tbc_sc_t'(`TBC_SC_RESET);
      sc_r[1]   <= tbc_sc_t'(`TBC_SC_RESET);
      armed_r   <= 2'h0;
      cap_blk_r <= 2'h0;
      cmp_blk_r <= 2'h0;
      irq_r     <= 2'h0;
      src_r     <= 1'b0;
    end
    else
    begin
      sc_r      <= sc_nxt;
      armed_r   <= armed_nxt;
      cap_blk_r <= cap_blk_nxt;
      cmp_blk_r <= cmp_blk_nxt;
      irq_r     <= irq_nxt;
      src_r     <= src_nxt;
    end
  end

  // Value registers have no reset value.
  always_ff @(posedge aclk)
  begin
    val_r <= val_nxt;
  end

  assign chan_irq = irq_r;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence flag_clear0;
    rif.wr_en && rif.wr_idx == `TBC_IDX_SC0 && !rif.wr_data[`TBC_SC_FLAG] && armed_r[0] && !ev[0];
  endsequence

  irq_gate_a:
  assert property (chan_irq[0] |-> $past(sc_r[0].channel_irq_enable))
    else $error("interrupt without enable");
  no_buf_ch1_a:
  assert property (!sc_r[1].chan0_buffered_select)
    else $error("buffered select set in channel 1");
  ch1_release_a:
  assert property (sc_r[0].chan0_buffered_select [*2] |=> pin_oe_n[1])
    else $error("channel 1 pin not released");
  flag_set_a:
  assert property (ev[0] |=> sc_r[0].channel_event_flag)
    else $error("event flag not set");
  flag_clear_a:
  assert property (flag_clear0 |=> !sc_r[0].channel_event_flag)
    else $error("flag clear sequence ignored");
  cap_hold_a:
  assert property ((cap_blk_r[0] && !rif.wr_en) |=> $stable(val_r[0]))
    else $error("capture during high byte hold");
  cmp_hold_a:
  assert property (cmp_blk_r[0] && !sc_r[0].chan0_buffered_select |-> !cmp_ev[0])
    else $error("compare during high byte write");
  buf_swap_a:
  assert property ((mode[0] == TBC_BUF && counter_overflow) |=> (src_r != $past(src_r)))
    else $error("buffered source not swapped");
endmodule : tbc_top

//--- bench/tbc_core_model.sv
// Model of the timer core counter and of the channel pins outside the block.
`timescale 1ns/100ps
module tbc_core_model #(
  parameter logic [15:0] MOD = 16'h00FF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        halt,
  input  wire logic        clear,
  input  wire logic [1:0]  ext_lvl,
  input  wire logic [1:0]  pin_out,
  input  wire logic [1:0]  pin_oe_n,
  output logic      [15:0] cnt,
  output logic             ovf,
  output logic      [1:0]  pin_in
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (halt && clear))
    begin
      cnt <= 16'h0000;
      ovf <= 1'b0;
    end
    else if (!halt)
    begin
      ovf <= (cnt == MOD);
      cnt <= (cnt == MOD) ? 16'h0000 : cnt + 16'h0001;
    end
    else
      ovf <= 1'b0;
  end
  // A pin that the block drives shows its drive value, otherwise the outside level.
  assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule : tbc_core_model

//--- bench/test_timer_channel_capture_compare.sv
// Self-checking testbench of the timer channel block.
`timescale 1ns/100ps
`include "tbc_defines.svh"
module test_timer_channel_capture_compare;
  import tbc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic bready = 1'b1, rready = 1'b1, halt = 1'b0, clear = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, d, h, v;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, r, pin_out, pin_oe_n, chan_irq, pin_in, ext_lvl = 2'b00, cd;
  logic awready, wready, bvalid, arready, rvalid, ovf;
  logic [15:0] cnt, c0;
  logic [3:0] obs;
  localparam logic [15:0] CNT_MOD = 16'h00FF;
  assign obs = {chan_irq, pin_out};
  int fail_count = 0, checked = 0, cyc = 0;
  always #5 aclk = ~aclk;
  tbc_core_model #(.MOD(CNT_MOD)) core_u (.aclk(aclk), .aresetn(aresetn), .halt(halt), .clear(clear), .ext_lvl(ext_lvl),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .cnt(cnt), .ovf(ovf), .pin_in(pin_in));
  tbc_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .counter_value(cnt), .counter_overflow(ovf), .counter_halt(halt),
    .counter_clear(clear), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .chan_irq(chan_irq));
  function automatic logic [7:0] ba(input logic [5:0] i);
    return {i, 2'b00};
  endfunction : ba
  // Counter value one clock after the given one, wrapping at the modulo value.
  function automatic logic [15:0] cnt_after(input logic [15:0] c);
    return (c == CNT_MOD) ? 16'h0000 : c + 16'h0001;
  endfunction : cnt_after
  task automatic results;
    $display("checks %0d fails %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    logic aw_t, w_t, b_t;
    awaddr <= a;
    wdata <= {24'h000000, dat};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      @(posedge aclk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] dat, output logic [1:0] rs);
    logic ar_t, r_t;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      dat = rdata[7:0];
      rs = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
  endtask : rd
  // Mode bits change only with the counter halted and cleared.
  task automatic mode(input logic [7:0] a, input logic [7:0] dat);
    halt <= 1'b1;
    clear <= 1'b1;
    wr(a, dat);
    halt <= 1'b0;
    clear <= 1'b0;
    @(posedge aclk);
  endtask : mode
  task automatic wsig(input int i, input logic val);
    int n;
    n = 0;
    do
    begin
      @(negedge aclk);
      n++;
    end while (obs[i] !== val && n < 300);
    cmp(obs[i], val);
    @(posedge aclk);
  endtask : wsig
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("ERROR t=%0t timeout", $time);
      results();
    end
  end
  initial
  begin
    void'($urandom(32'h709f));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    cmp(pin_oe_n, 2'b11);
    rd(ba(`TBC_IDX_SC0), d, r);
    cmp(d, `TBC_SC_RESET);
    rd(8'hF0, d, r);
    cmp(r, `TBC_RESP_SLVERR);
    mode(ba(`TBC_IDX_SC0), 8'h1C);
    v = 8'h10 + 8'($urandom % 8'hD0);
    wr(ba(`TBC_IDX_V0H), 8'h00);
    wr(ba(`TBC_IDX_V0L), v);
    rd(ba(`TBC_IDX_V0L), d, r);
    cmp(d, v);
    for (int k = 0; k < 4; k++)
    begin
      cd = (k == 0) ? 2'b10 : (k == 1) ? 2'b11 : 2'b01;
      wr(ba(`TBC_IDX_SC0), {4'h1, cd, 2'b00});
      wsig(0, k[0]);
    end
    wr(ba(`TBC_IDX_SC0), 8'h18);
    wsig(0, 1'b0);
    wr(ba(`TBC_IDX_SC0), 8'h18);
    wr(ba(`TBC_IDX_V0H), 8'h00);
    repeat (300) @(posedge aclk);
    rd(ba(`TBC_IDX_SC0), d, r);
    cmp(d, 8'h18);
    cmp(pin_out[0], 1'b0);
    wr(ba(`TBC_IDX_V0L), v);
    wr(ba(`TBC_IDX_SC0), 8'h5C);
    wsig(2, 1'b1);
    wr(ba(`TBC_IDX_SC0), 8'h5C);
    rd(ba(`TBC_IDX_SC0), d, r);
    cmp(d, 8'hDC);
    wr(ba(`TBC_IDX_SC0), 8'h5C);
    rd(ba(`TBC_IDX_SC0), d, r);
    cmp(d, 8'h5C);
    for (int c = 1; c < 4; c++)
      for (int e = 0; e < 2; e++)
      begin
        wr(ba(`TBC_IDX_SC1), {4'h0, 2'(c), 2'b00});
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        c0 = cnt;
        @(posedge aclk);
        ext_lvl[1] <= ~ext_lvl[1];
        repeat (4) @(posedge aclk);
        rd(ba(`TBC_IDX_SC1), d, r);
        cmp(d[7], (e == 0) ? c[0] : c[1]);
        if (d[7] === 1'b1)
        begin
          rd(ba(`TBC_IDX_V1H), h, r);
          rd(ba(`TBC_IDX_V1L), d, r);
          cmp({h, d}, cnt_after(c0));
        end
      end
    mode(ba(`TBC_IDX_SC1), 8'h14);
    cmp(pin_oe_n[1], 1'b0);
    mode(ba(`TBC_IDX_SC0), 8'h28);
    rd(ba(`TBC_IDX_SC1), d, r);
    cmp(d, 8'h00);
    cmp(pin_oe_n[1], 1'b1);
    wsig(0, 1'b0);
    repeat (300) @(posedge aclk);
    results();
  end
endmodule : test_timer_channel_capture_compare
